// file: inc/irpc_pkg.sv
// Shared constants and types for the ring port event counters
package irpc_pkg;

    localparam int unsigned IRPC_ADDR_W = 8;
    localparam int unsigned IRPC_DATA_W = 32;
    localparam int unsigned IRPC_CTR_W = 48;
    localparam int unsigned IRPC_INC_W = 10;
    localparam int unsigned IRPC_DEPTH_W = 8;
    localparam int unsigned IRPC_FILTER_W = 15;

    // Register byte offsets
    localparam logic [7:0] IRPC_OFS_CTL0_LO = 8'h00;
    localparam logic [7:0] IRPC_OFS_CTL0_HI = 8'h04;
    localparam logic [7:0] IRPC_OFS_CTL1_LO = 8'h08;
    localparam logic [7:0] IRPC_OFS_CTL1_HI = 8'h0c;
    localparam logic [7:0] IRPC_OFS_CTR0_LO = 8'h10;
    localparam logic [7:0] IRPC_OFS_CTR0_HI = 8'h14;
    localparam logic [7:0] IRPC_OFS_CTR1_LO = 8'h18;
    localparam logic [7:0] IRPC_OFS_CTR1_HI = 8'h1c;

    // Control word fields, low word
    localparam int unsigned IRPC_CTL_EVENT_LSB = 0;
    localparam int unsigned IRPC_CTL_UMASK_LSB = 8;
    localparam int unsigned IRPC_CTL_CLEAR_BIT = 17;
    localparam int unsigned IRPC_CTL_ENABLE_BIT = 22;
    // Control word fields, high word: bits [50:36] land at [18:4]
    localparam int unsigned IRPC_CTL_FILTER_LSB = 4;

    // Extra filter layout
    localparam int unsigned IRPC_FLT_PART_LSB = 0;
    localparam int unsigned IRPC_FLT_XLATE_LSB = 8;
    localparam int unsigned IRPC_FLT_PREFIX_LSB = 12;
    localparam logic [2:0] IRPC_FLT_PREFIX = 3'h7;

    // Values after reset
    localparam logic [31:0] IRPC_REG_RESET = 32'h0000_0000;
    localparam logic [7:0] IRPC_CODE_RESET = 8'h00;

    // Event codes
    localparam logic [7:0] IRPC_EV_NOTHING = 8'h00;
    localparam logic [7:0] IRPC_EV_CLOCKTICKS = 8'h01;
    localparam logic [7:0] IRPC_EV_DRESP_INS = 8'h02;
    localparam logic [7:0] IRPC_EV_BYPASS_INS = 8'h03;
    localparam logic [7:0] IRPC_EV_STD_INS = 8'h04;
    localparam logic [7:0] IRPC_EV_DRESP_FULL = 8'h05;
    localparam logic [7:0] IRPC_EV_BYPASS_FULL = 8'h06;
    localparam logic [7:0] IRPC_EV_STD_FULL = 8'h07;
    localparam logic [7:0] IRPC_EV_DRESP_OCC = 8'h08;
    localparam logic [7:0] IRPC_EV_BYPASS_OCC = 8'h09;
    localparam logic [7:0] IRPC_EV_STD_OCC = 8'h0a;
    localparam logic [7:0] IRPC_EV_OUT_REQ_DEPTH = 8'h0c;
    localparam logic [7:0] IRPC_EV_CACHE_OCC = 8'h0f;
    localparam logic [7:0] IRPC_EV_RDQ_ALLOC = 8'h16;
    localparam logic [7:0] IRPC_EV_RDQ_FULL = 8'h17;
    localparam logic [7:0] IRPC_EV_RDQ_INSERT = 8'h18;
    localparam logic [7:0] IRPC_EV_RDQ_OCC = 8'h19;
    localparam logic [7:0] IRPC_EV_STALL_REQ0 = 8'h1a;
    localparam logic [7:0] IRPC_EV_STALL_REQ1 = 8'h1b;
    localparam logic [7:0] IRPC_EV_STALL_REQ01 = 8'h1c;
    localparam logic [7:0] IRPC_EV_STALL_DATA = 8'h1d;
    localparam logic [7:0] IRPC_EV_MISC_A = 8'h1e;
    localparam logic [7:0] IRPC_EV_MISC_B = 8'h1f;
    localparam logic [7:0] IRPC_EV_BUF_ALLOC = 8'h20;
    localparam logic [7:0] IRPC_EV_CARD_REQ = 8'h84;

    // Egress queue index: data response, bypass, standard
    localparam int unsigned IRPC_EG_DRESP = 0;
    localparam int unsigned IRPC_EG_BYPASS = 1;
    localparam int unsigned IRPC_EG_STD = 2;

    // Stall index: request channel 0, request channel 1, data channel
    localparam int unsigned IRPC_ST_REQ0 = 0;
    localparam int unsigned IRPC_ST_REQ1 = 1;
    localparam int unsigned IRPC_ST_DATA = 2;

    typedef struct packed {
        logic [7:0] cache_read_depth;
        logic [7:0] cache_write_depth;
        logic [7:0] cache_snoop_depth;
        logic [7:0] cache_mem_depth;
        logic read_q_full;
        logic read_q_insert;
        logic [7:0] read_q_depth;
        logic read_q_alloc;
        logic buf_insert;
        logic buf_evict;
        logic [7:0] misc_a;
        logic [6:0] misc_b;
        logic card_req_valid;
        logic [7:0] card_req_kind;
        logic [2:0] card_req_part;
        logic card_req_xlate;
        logic [2:0] egress_insert;
        logic [2:0] egress_full;
        logic [7:0] data_resp_depth;
        logic [7:0] bypass_depth;
        logic [7:0] standard_depth;
        logic [2:0] stall;
        logic [7:0] outbound_req_depth;
    } irpc_events_type;

endpackage : irpc_pkg

// file: src/irpc_counter.sv
// One programmable event counter with word-wide software writes
module irpc_counter #(
    parameter int unsigned WIDTH = irpc_pkg::IRPC_CTR_W
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic enable_in,
    input wire logic clear_in,
    input wire logic [irpc_pkg::IRPC_INC_W-1:0] inc_in,
    input wire logic wr_lo_in,
    input wire logic wr_hi_in,
    input wire logic [31:0] wr_data_in,
    output logic [WIDTH-1:0] count_out
);

    logic [WIDTH-1:0] next_count;

    always_comb
    begin
        next_count = count_out;
        if (enable_in)
        begin
            next_count = count_out + WIDTH'(inc_in);
        end
        // Software write lands on top of this cycle's increment
        if (wr_lo_in)
        begin
            next_count[31:0] = wr_data_in;
        end
        if (wr_hi_in)
        begin
            next_count[WIDTH-1:32] = wr_data_in[WIDTH-33:0];
        end
        if (clear_in)
        begin
            next_count = '0;
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            count_out <= '0;
        end
        else
        begin
            count_out <= next_count;
        end
    end

endmodule : irpc_counter

// file: src/irpc_port_counters.sv
// Ring port monitoring unit: two event counters with register port
module irpc_port_counters #(
    parameter int unsigned CTR_WIDTH = irpc_pkg::IRPC_CTR_W
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [irpc_pkg::IRPC_ADDR_W-1:0] addr_in,
    input wire logic [31:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire irpc_pkg::irpc_events_type events_in,
    output logic [31:0] rd_data_out
);

    localparam int unsigned IW = irpc_pkg::IRPC_INC_W;
    localparam int unsigned DW = irpc_pkg::IRPC_DEPTH_W;

    // Widen a queue depth to increment width
    function automatic logic [IW-1:0] irpc_depth(
        input logic [DW-1:0] depth
    );
        irpc_depth = {{(IW-DW){1'b0}}, depth};
    endfunction : irpc_depth

    // Widen a one-cycle event to increment width
    function automatic logic [IW-1:0] irpc_one(input logic hit);
        irpc_one = {{(IW-1){1'b0}}, hit};
    endfunction : irpc_one

    // Per-cycle increment for one counter's selection
    function automatic logic [IW-1:0] irpc_increment(
        input logic [7:0] code,
        input logic [7:0] umask,
        input logic [irpc_pkg::IRPC_FILTER_W-1:0] flt,
        input irpc_pkg::irpc_events_type ev
    );
        logic [IW-1:0] inc;
        logic prefix_ok;
        logic where_ok;
        logic card_hit;
        inc = '0;
        prefix_ok = flt[irpc_pkg::IRPC_FLT_PREFIX_LSB +: 3]
                    == irpc_pkg::IRPC_FLT_PREFIX;
        where_ok = flt[irpc_pkg::IRPC_FLT_PART_LSB + ev.card_req_part]
                   | flt[irpc_pkg::IRPC_FLT_XLATE_LSB
                         + int'(ev.card_req_xlate)];
        card_hit = ev.card_req_valid & prefix_ok & where_ok
                   & (|(umask & ev.card_req_kind));
        case (code)
            irpc_pkg::IRPC_EV_CLOCKTICKS:
                inc = irpc_one(1'b1);
            irpc_pkg::IRPC_EV_CACHE_OCC:
            begin
                if (umask[0])
                begin
                    inc = irpc_depth(ev.cache_read_depth)
                          + irpc_depth(ev.cache_write_depth);
                end
                if (umask[1])
                begin
                    inc = inc + irpc_depth(ev.cache_snoop_depth);
                end
                if (umask[2])
                begin
                    inc = inc + irpc_depth(ev.cache_mem_depth);
                end
            end
            irpc_pkg::IRPC_EV_RDQ_FULL:
                inc = irpc_one(ev.read_q_full);
            irpc_pkg::IRPC_EV_RDQ_INSERT:
                inc = irpc_one(ev.read_q_insert);
            irpc_pkg::IRPC_EV_RDQ_OCC:
                inc = irpc_depth(ev.read_q_depth);
            irpc_pkg::IRPC_EV_RDQ_ALLOC:
                inc = irpc_one(ev.read_q_alloc);
            irpc_pkg::IRPC_EV_BUF_ALLOC:
                inc = irpc_one((umask[0] & ev.buf_insert)
                               | (umask[2] & ev.buf_evict));
            irpc_pkg::IRPC_EV_MISC_A:
                inc = irpc_one(|(umask & ev.misc_a));
            irpc_pkg::IRPC_EV_MISC_B:
                inc = irpc_one(|(umask[6:0] & ev.misc_b));
            irpc_pkg::IRPC_EV_CARD_REQ:
                inc = irpc_one(card_hit);
            irpc_pkg::IRPC_EV_DRESP_FULL:
                inc = irpc_one(ev.egress_full[irpc_pkg::IRPC_EG_DRESP]);
            irpc_pkg::IRPC_EV_BYPASS_FULL:
                inc = irpc_one(ev.egress_full[irpc_pkg::IRPC_EG_BYPASS]);
            irpc_pkg::IRPC_EV_STD_FULL:
                inc = irpc_one(ev.egress_full[irpc_pkg::IRPC_EG_STD]);
            irpc_pkg::IRPC_EV_DRESP_OCC:
                inc = irpc_depth(ev.data_resp_depth);
            irpc_pkg::IRPC_EV_BYPASS_OCC:
                inc = irpc_depth(ev.bypass_depth);
            irpc_pkg::IRPC_EV_STD_OCC:
                inc = irpc_depth(ev.standard_depth);
            irpc_pkg::IRPC_EV_DRESP_INS:
                inc = irpc_one(ev.egress_insert[irpc_pkg::IRPC_EG_DRESP]);
            irpc_pkg::IRPC_EV_BYPASS_INS:
                inc = irpc_one(ev.egress_insert[irpc_pkg::IRPC_EG_BYPASS]);
            irpc_pkg::IRPC_EV_STD_INS:
                inc = irpc_one(ev.egress_insert[irpc_pkg::IRPC_EG_STD]);
            irpc_pkg::IRPC_EV_STALL_REQ0:
                inc = irpc_one(ev.stall[irpc_pkg::IRPC_ST_REQ0]);
            irpc_pkg::IRPC_EV_STALL_REQ1:
                inc = irpc_one(ev.stall[irpc_pkg::IRPC_ST_REQ1]);
            irpc_pkg::IRPC_EV_STALL_REQ01:
                // Stalls on both request channels count as two
                inc = irpc_one(ev.stall[irpc_pkg::IRPC_ST_REQ0])
                      + irpc_one(ev.stall[irpc_pkg::IRPC_ST_REQ1]);
            irpc_pkg::IRPC_EV_STALL_DATA:
                inc = irpc_one(ev.stall[irpc_pkg::IRPC_ST_DATA]);
            irpc_pkg::IRPC_EV_OUT_REQ_DEPTH:
                inc = irpc_depth(ev.outbound_req_depth);
            default:
                // Unlisted codes, including the null event, count nothing
                inc = '0;
        endcase
        irpc_increment = inc;
    endfunction : irpc_increment

    logic [7:0] event_code [2];
    logic [7:0] unit_mask [2];
    logic count_enable [2];
    logic [irpc_pkg::IRPC_FILTER_W-1:0] extra_filter [2];
    logic clear_pulse [2];
    logic [IW-1:0] increment [2];
    logic [CTR_WIDTH-1:0] count [2];
    logic [CTR_WIDTH-33:0] hi_snapshot;
    logic [31:0] next_rd_data;

    // Control write decode: low word holds code, mask, enable
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            for (int i = 0; i < 2; i++)
            begin
                event_code[i] <= irpc_pkg::IRPC_CODE_RESET;
                unit_mask[i] <= irpc_pkg::IRPC_CODE_RESET;
                count_enable[i] <= 1'b0;
                clear_pulse[i] <= 1'b0;
            end
        end
        else
        begin
            clear_pulse[0] <= 1'b0;
            clear_pulse[1] <= 1'b0;
            for (int i = 0; i < 2; i++)
            begin
                if (wr_in && addr_in == (i == 0 ?
                    irpc_pkg::IRPC_OFS_CTL0_LO :
                    irpc_pkg::IRPC_OFS_CTL1_LO))
                begin
                    event_code[i] <=
                        wr_data_in[irpc_pkg::IRPC_CTL_EVENT_LSB +: 8];
                    unit_mask[i] <=
                        wr_data_in[irpc_pkg::IRPC_CTL_UMASK_LSB +: 8];
                    count_enable[i] <=
                        wr_data_in[irpc_pkg::IRPC_CTL_ENABLE_BIT];
                    clear_pulse[i] <=
                        wr_data_in[irpc_pkg::IRPC_CTL_CLEAR_BIT];
                end
            end
        end
    end

    // Control write decode: high word holds the extra filter
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            extra_filter[0] <= '0;
            extra_filter[1] <= '0;
        end
        else
        begin
            if (wr_in && addr_in == irpc_pkg::IRPC_OFS_CTL0_HI)
            begin
                extra_filter[0] <= wr_data_in[irpc_pkg::IRPC_CTL_FILTER_LSB
                    +: irpc_pkg::IRPC_FILTER_W];
            end
            if (wr_in && addr_in == irpc_pkg::IRPC_OFS_CTL1_HI)
            begin
                extra_filter[1] <= wr_data_in[irpc_pkg::IRPC_CTL_FILTER_LSB
                    +: irpc_pkg::IRPC_FILTER_W];
            end
        end
    end

    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            increment[i] = irpc_increment(event_code[i], unit_mask[i],
                extra_filter[i], events_in);
        end
    end

    irpc_counter #(
        .WIDTH(CTR_WIDTH)
    ) u_counter0 (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .enable_in(count_enable[0]),
        .clear_in(clear_pulse[0]),
        .inc_in(increment[0]),
        .wr_lo_in(wr_in && addr_in == irpc_pkg::IRPC_OFS_CTR0_LO),
        .wr_hi_in(wr_in && addr_in == irpc_pkg::IRPC_OFS_CTR0_HI),
        .wr_data_in(wr_data_in),
        .count_out(count[0])
    );

    irpc_counter #(
        .WIDTH(CTR_WIDTH)
    ) u_counter1 (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .enable_in(count_enable[1]),
        .clear_in(clear_pulse[1]),
        .inc_in(increment[1]),
        .wr_lo_in(wr_in && addr_in == irpc_pkg::IRPC_OFS_CTR1_LO),
        .wr_hi_in(wr_in && addr_in == irpc_pkg::IRPC_OFS_CTR1_HI),
        .wr_data_in(wr_data_in),
        .count_out(count[1])
    );

    // Low-word read freezes the upper bits, so a lo-then-hi pair is
    // coherent even if a carry ripples between the two reads
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            hi_snapshot <= '0;
        end
        else if (rd_in && addr_in == irpc_pkg::IRPC_OFS_CTR0_LO)
        begin
            hi_snapshot <= count[0][CTR_WIDTH-1:32];
        end
        else if (rd_in && addr_in == irpc_pkg::IRPC_OFS_CTR1_LO)
        begin
            hi_snapshot <= count[1][CTR_WIDTH-1:32];
        end
    end

    always_comb
    begin
        next_rd_data = irpc_pkg::IRPC_REG_RESET;
        if (rd_in)
        begin
            case (addr_in)
                irpc_pkg::IRPC_OFS_CTL0_LO,
                irpc_pkg::IRPC_OFS_CTL1_LO:
                begin
                    next_rd_data[irpc_pkg::IRPC_CTL_EVENT_LSB +: 8] =
                        event_code[addr_in[3]];
                    next_rd_data[irpc_pkg::IRPC_CTL_UMASK_LSB +: 8] =
                        unit_mask[addr_in[3]];
                    next_rd_data[irpc_pkg::IRPC_CTL_ENABLE_BIT] =
                        count_enable[addr_in[3]];
                end
                irpc_pkg::IRPC_OFS_CTL0_HI,
                irpc_pkg::IRPC_OFS_CTL1_HI:
                    next_rd_data[irpc_pkg::IRPC_CTL_FILTER_LSB
                        +: irpc_pkg::IRPC_FILTER_W] = extra_filter[addr_in[3]];
                irpc_pkg::IRPC_OFS_CTR0_LO:
                    next_rd_data = count[0][31:0];
                irpc_pkg::IRPC_OFS_CTR1_LO:
                    next_rd_data = count[1][31:0];
                irpc_pkg::IRPC_OFS_CTR0_HI,
                irpc_pkg::IRPC_OFS_CTR1_HI:
                    next_rd_data[CTR_WIDTH-33:0] = hi_snapshot;
                default:
                    next_rd_data = irpc_pkg::IRPC_REG_RESET;
            endcase
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            rd_data_out <= irpc_pkg::IRPC_REG_RESET;
        end
        else
        begin
            rd_data_out <= next_rd_data;
        end
    end

endmodule : irpc_port_counters

// file: tb/irpc_port_counters_properties.sv
// Port-level checker for the ring port event counters
module irpc_port_counters_checker #(
    parameter int unsigned CTR_WIDTH = 48
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [irpc_pkg::IRPC_ADDR_W-1:0] addr_in,
    input wire logic [31:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire irpc_pkg::irpc_events_type events_in,
    input wire logic [31:0] rd_data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] ctl0;
    logic [31:0] ctl1;
    logic tick0;

    // Shadow of the control words as software should read them back
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            ctl0 <= 32'h0;
            ctl1 <= 32'h0;
        end
        else if (wr_in && addr_in == 8'h00)
            ctl0 <= wr_data_in & 32'h0040_ffff;
        else if (wr_in && addr_in == 8'h08)
            ctl1 <= wr_data_in & 32'h0040_ffff;
    end

    assign tick0 = ctl0[22] && ctl0[7:0] == 8'h01;

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);

    a_idle_read_zero: assert property (
        !$past(rd_in) |-> rd_data_out == 32'h0)
        else $error("read data outside read slot");
    a_reset_read_zero: assert property (disable iff (1'b0)
        rst_in |=> rd_data_out == 32'h0)
        else $error("read data not zero after reset");
    a_unmapped_read_zero: assert property (
        rd_in && addr_in > 8'h1c |=> rd_data_out == 32'h0)
        else $error("unmapped read not zero");
    a_ctl0_read_back: assert property (
        rd_in && addr_in == 8'h00 |=> rd_data_out == $past(ctl0))
        else $error("control 0 read back wrong");
    a_ctl1_read_back: assert property (
        rd_in && addr_in == 8'h08 |=> rd_data_out == $past(ctl1))
        else $error("control 1 read back wrong");
    a_filter_read_back: assert property (
        wr_in && addr_in == 8'h04 ##1 !wr_in ##1 rd_in && addr_in == 8'h04
        |=> rd_data_out == ($past(wr_data_in, 3) & 32'h0007_fff0))
        else $error("filter read back wrong");
    a_clear_zeroes_count: assert property (
        wr_in && addr_in == 8'h00 && wr_data_in[17] && !wr_data_in[22]
        ##1 !wr_in ##1 rd_in && addr_in == 8'h10 |=> rd_data_out == 32'h0)
        else $error("count not cleared");
    a_tick_step_one: assert property (
        rd_in && addr_in == 8'h10 && tick0 && !wr_in
        ##1 rd_in && addr_in == 8'h10 && !wr_in
        |=> rd_data_out == $past(rd_data_out) + 32'h1)
        else $error("tick count step not one");
    a_count_write_read: assert property (
        !ctl0[22] && wr_in && addr_in == 8'h10 ##1 !wr_in
        ##1 rd_in && addr_in == 8'h10 |=> rd_data_out == $past(wr_data_in, 3))
        else $error("count write not read back");

    c_tick_step: cover property (rd_in && tick0 ##1 rd_in);
    c_clear: cover property (wr_in && addr_in == 8'h00 && wr_data_in[17]);
    c_unmapped: cover property (rd_in && addr_in > 8'h1c);
endmodule : irpc_port_counters_checker

bind irpc_port_counters irpc_port_counters_checker #(
    .CTR_WIDTH(CTR_WIDTH)
) u_checker (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .addr_in(addr_in),
    .wr_data_in(wr_data_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .events_in(events_in),
    .rd_data_out(rd_data_out)
);

// file: tb/tb_io_ring_port_event_counters.sv
// Self-checking bench for the ring port event counters
module tb_io_ring_port_event_counters;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_in;
    logic rst_in;
    logic [7:0] addr_in;
    logic [31:0] wr_data_in;
    logic wr_in;
    logic rd_in;
    irpc_pkg::irpc_events_type ev;
    logic [31:0] rd_data_out;
    int error_cnt = 0;
    int comparisons = 0;
    int cycles = 0;

    irpc_port_counters u_dut (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .addr_in(addr_in),
        .wr_data_in(wr_data_in),
        .wr_in(wr_in),
        .rd_in(rd_in),
        .events_in(ev),
        .rd_data_out(rd_data_out)
    );

    initial
    begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    // Whole run needs under a thousand cycles
    always @(posedge clock_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            error_cnt++;
            finish_test();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_in <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                          input string what);
        @(posedge clock_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        #1;
        chk(what, exp, rd_data_out);
    endtask : rd_chk

    // Enable write, two idle cycles, disable write: four counted cycles
    task automatic meas(input int c, input logic [7:0] code,
                        input logic [7:0] um, input logic [14:0] flt,
                        input logic [31:0] exp);
        logic [7:0] base;
        base = 8'(c * 8);
        wr_reg(base + 8'h04, {13'h0, flt, 4'h0});
        wr_reg(base, 32'h0002_0000);
        rd_chk(base + 8'h10, 32'h0, "cleared count");
        wr_reg(base, {9'h0, 1'b1, 6'h0, um, code});
        repeat (2) @(posedge clock_in);
        wr_reg(base, {16'h0, um, code});
        rd_chk(base + 8'h10, exp, "event count");
        rd_chk(base + 8'h14, 32'h0, "count high");
    endtask : meas

    task automatic t_reset();
        for (int a = 0; a <= 32; a += 4)
            rd_chk(8'(a), 32'h0, "reset value");
        $display("test reset done");
    endtask : t_reset

    task automatic t_regs();
        wr_reg(8'h00, 32'hffff_ffff);
        wr_reg(8'h08, 32'hffbf_1234);
        wr_reg(8'h04, 32'hffff_ffff);
        rd_chk(8'h04, 32'h0007_fff0, "filter word");
        rd_chk(8'h00, 32'h0040_ffff, "control 0");
        rd_chk(8'h08, 32'h0000_1234, "control 1");
        rd_chk(8'h0c, 32'h0, "filter 1");
        wr_reg(8'h00, 32'h0);
        wr_reg(8'h08, 32'h0);
        $display("test registers done");
    endtask : t_regs

    task automatic t_wide();
        wr_reg(8'h10, 32'hffff_fffe);
        rd_chk(8'h10, 32'hffff_fffe, "count low write");
        wr_reg(8'h14, 32'h0000_1234);
        wr_reg(8'h00, 32'h0040_0001);
        repeat (2) @(posedge clock_in);
        wr_reg(8'h00, 32'h0000_0001);
        rd_chk(8'h10, 32'h0000_0002, "wide low");
        rd_chk(8'h14, 32'h0000_1235, "wide high");
        $display("test wide done");
    endtask : t_wide

    task automatic t_step();
        logic [31:0] d1;
        wr_reg(8'h00, 32'h0040_0001);
        @(posedge clock_in);
        addr_in <= 8'h10;
        rd_in <= 1'b1;
        @(posedge clock_in);
        #1;
        d1 = rd_data_out;
        @(posedge clock_in);
        rd_in <= 1'b0;
        #1;
        chk("tick step", 32'h1, rd_data_out - d1);
        wr_reg(8'h00, 32'h0);
        $display("test step done");
    endtask : t_step

    // Reset in mid-run must drop a live setup back to idle
    task automatic t_midreset();
        wr_reg(8'h04, 32'h0007_fff0);
        wr_reg(8'h00, 32'h0040_0001);
        @(posedge clock_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        rst_in <= 1'b0;
        rd_chk(8'h00, 32'h0, "control after reset");
        rd_chk(8'h04, 32'h0, "filter after reset");
        rd_chk(8'h10, 32'h0, "count after reset");
        $display("test midreset done");
    endtask : t_midreset

    task automatic t_events();
        ev = '0;
        ev.cache_read_depth = 8'd3;
        ev.cache_write_depth = 8'd2;
        ev.cache_snoop_depth = 8'd4;
        ev.cache_mem_depth = 8'd6;
        meas(0, 8'h0f, 8'h01, 15'h0, 32'd20);
        meas(1, 8'h0f, 8'h02, 15'h0, 32'd16);
        meas(0, 8'h0f, 8'h04, 15'h0, 32'd24);
        meas(1, 8'h0f, 8'h07, 15'h0, 32'd60);
        ev = '0;
        ev.read_q_full = 1'b1;
        meas(1, 8'h17, 8'h00, 15'h0, 32'd4);
        meas(0, 8'h18, 8'h00, 15'h0, 32'd0);
        ev.read_q_insert = 1'b1;
        meas(0, 8'h18, 8'h00, 15'h0, 32'd4);
        ev.read_q_depth = 8'd9;
        meas(1, 8'h19, 8'h00, 15'h0, 32'd36);
        ev.read_q_alloc = 1'b1;
        meas(0, 8'h16, 8'h00, 15'h0, 32'd4);
        ev.buf_insert = 1'b1;
        meas(1, 8'h20, 8'h01, 15'h0, 32'd4);
        meas(0, 8'h20, 8'h04, 15'h0, 32'd0);
        ev.buf_evict = 1'b1;
        meas(1, 8'h20, 8'h04, 15'h0, 32'd4);
        ev.outbound_req_depth = 8'd11;
        meas(0, 8'h0c, 8'h00, 15'h0, 32'd44);
        ev = '0;
        ev.data_resp_depth = 8'd3;
        ev.bypass_depth = 8'd5;
        ev.standard_depth = 8'd7;
        for (int i = 0; i < 3; i++)
        begin
            ev.egress_insert = 3'(1 << i);
            ev.egress_full = 3'(1 << i);
            ev.stall = 3'(1 << i);
            meas(i % 2, 8'h02 + 8'(i), 8'h00, 15'h0, 32'd4);
            meas(i % 2, 8'h05 + 8'(i), 8'h00, 15'h0, 32'd4);
            meas(i % 2, 8'h08 + 8'(i), 8'h00, 15'h0, 32'(12 + 8 * i));
            meas(i % 2, (i == 2) ? 8'h1d : 8'h1a + 8'(i), 8'h00, 15'h0,
                 32'd4);
        end
        // Both request channels stalled count two per cycle
        ev.stall = 3'b011;
        meas(0, 8'h1c, 8'h00, 15'h0, 32'd8);
        meas(1, 8'h00, 8'hff, 15'h7fff, 32'd0);
        for (int b = 0; b < 8; b++)
        begin
            ev = '0;
            ev.misc_a = 8'(1 << b);
            meas(b % 2, 8'h1e, 8'(1 << b), 15'h0, 32'd4);
            ev.misc_b = 7'(1 << b);
            if (b < 7)
                meas((b + 1) % 2, 8'h1f, 8'(1 << b), 15'h0, 32'd4);
        end
        ev.misc_a = 8'h03;
        meas(0, 8'h1e, 8'h03, 15'h0, 32'd4);
        ev = '0;
        ev.card_req_valid = 1'b1;
        for (int k = 4; k < 8; k++)
        begin
            ev.card_req_kind = 8'(1 << k);
            ev.card_req_part = 3'(k - 4);
            if (k != 5)
                meas(k % 2, 8'h84, 8'(1 << k), 15'h7000 | 15'(1 << (k - 4)),
                     32'd4);
        end
        ev.card_req_xlate = 1'b1;
        meas(0, 8'h84, 8'h80, 15'h7200, 32'd4);
        meas(1, 8'h84, 8'h80, 15'h0fff, 32'd0);
        ev = '0;
        $display("test events done");
    endtask : t_events

    initial
    begin
        rst_in = 1'b1;
        addr_in = 8'h0;
        wr_data_in = 32'h0;
        wr_in = 1'b0;
        rd_in = 1'b0;
        ev = '0;
        repeat (8) @(posedge clock_in);
        rst_in <= 1'b0;
        t_reset();
        t_regs();
        t_wide();
        t_step();
        t_midreset();
        t_events();
        finish_test();
    end
endmodule : tb_io_ring_port_event_counters
